/* design/zone_decode_params.svh */
// Register offsets, field positions, reset values and zone addresses.
`ifndef ZONE_DECODE_PARAMS_SVH
`define ZONE_DECODE_PARAMS_SVH

`define OFS_ACTIVATE      8'h30
`define OFS_BASE_HIGH     8'h60
`define OFS_BASE_LOW      8'h61
`define OFS_IRQ_NUM_WAKE  8'h70
`define OFS_IRQ_TYPE      8'h71
`define OFS_DMA_FIRST     8'h74
`define OFS_DMA_SECOND    8'h75
`define OFS_ZONE_CONFIG   8'hF0
`define OFS_ZONE_BASE_HI  8'hF1
`define OFS_ZONE_BASE_LO  8'hF2
`define OFS_ZONE_SIZE     8'hF3
`define OFS_MEM_CONFIG    8'hF4
`define OFS_MEM_BASE_HI   8'hF5
`define OFS_MEM_BASE_LO   8'hF6
`define OFS_MEM_SIZE      8'hF7
`define OFS_IRQ_MAP_AB    8'hF8
`define OFS_IRQ_MAP_CD    8'hF9
`define OFS_CS0_MAP       8'hFA
`define OFS_CS1_MAP       8'hFB

`define RESET_BYTE        8'h00
`define NO_DMA_CODE       8'h04
`define BASE_LOW_RW_MASK  8'hF0
`define ACTIVATE_BIT      0

`define CFG_KBD_EN        0
`define CFG_KBD_ALT       1
`define CFG_PWR_EN        2
`define CFG_PWR_ALT       3
`define CFG_RTC_LO        4
`define CFG_RTC_HI        5
`define CFG_USER_EN       6
`define CFG_DBG_EN        7
`define RTC_OFF           2'h0
`define RTC_LEGACY        2'h1
`define RTC_ALT_ONE       2'h2
`define RTC_ALT_TWO       2'h3
`define SIZE_HI           3
`define SIZE_LO           0
`define SIZE_MIN          4'h1
`define SIZE_MAX          4'h8

`define KBD_ADDR_A        16'h0060
`define KBD_ADDR_B        16'h0064
`define KBD_ALT_A         16'h0068
`define KBD_ALT_B         16'h006C
`define PWR_ADDR_A        16'h0062
`define PWR_ADDR_B        16'h0066
`define PWR_ALT_A         16'h006A
`define PWR_ALT_B         16'h006E
`define RTC_ADDR_A        16'h0070
`define RTC_ADDR_B        16'h0071
`define RTC_ALT1_A        16'h0072
`define RTC_ALT1_B        16'h0073
`define RTC_ALT2_A        16'h0074
`define RTC_ALT2_B        16'h0075
`define DBG_ADDR          16'h0080

`define ZONE_KBD          0
`define ZONE_PWR          1
`define ZONE_RTC          2
`define ZONE_USER         3
`define ZONE_DBG          4
`define NUM_ZONES         5
`define NUM_CS            2

`endif

/* design/zone_decode_pkg.sv */
// Types shared by the zone decoder: phase enum and register state.
package zone_decode_pkg;

    typedef enum logic [0:0] {
        PH_IDLE   = 1'b0,
        PH_ACCESS = 1'b1
    } phase_type;

    typedef struct packed {
        logic [7:0]  activate;
        logic [7:0]  base_high;
        logic [7:0]  base_low;
        logic [7:0]  zone_config;
        logic [7:0]  zone_base_high;
        logic [7:0]  zone_base_low;
        logic [7:0]  zone_size;
        logic [7:0]  mem_config;
        logic [7:0]  mem_base_high;
        logic [7:0]  mem_base_low;
        logic [7:0]  mem_size;
        logic [7:0]  irq_map_ab;
        logic [7:0]  irq_map_cd;
        logic [4:0]  cs0_map;
        logic [4:0]  cs1_map;
        phase_type   phase;
        logic [7:0]  cfg_rdata;
        logic [1:0]  chip_selects;
        logic [15:0] ext_addr;
        logic [7:0]  ext_wdata;
        logic        ext_wr;
        logic        ext_rd;
        logic [7:0]  io_rdata;
        logic        io_done;
    } state_type;

endpackage : zone_decode_pkg

/* design/zone_sel_if.sv */
// Internal zone select lines from the decoder to the chip-select router.
`include "zone_decode_params.svh"
interface zone_sel_if;
    logic [`NUM_ZONES-1:0] sel;
    modport source (output sel);
    modport sink   (input sel);
endinterface : zone_sel_if

/* design/io_zone_matcher.sv */
// Decodes an I/O address against the five enabled zones.
`include "zone_decode_params.svh"
module io_zone_matcher (
    input  wire logic        active,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  zone_config,
    input  wire logic [7:0]  zone_base_high,
    input  wire logic [7:0]  zone_base_low,
    input  wire logic [7:0]  zone_size,
    zone_sel_if.source       sel_port
);

    // Legacy zones answer at a pair of addresses.
    function automatic logic pair_hit(input logic [15:0] addr,
                                      input logic [15:0] a,
                                      input logic [15:0] b);
        pair_hit = (addr == a) || (addr == b);
    endfunction : pair_hit

    logic [3:0]  size_n;
    logic        size_ok;
    logic [15:0] user_mask;
    logic [15:0] user_base;
    logic        kbd_hit;
    logic        pwr_hit;
    logic        rtc_hit;

    // A size outside 1..8 leaves the user zone closed rather than huge.
    assign size_n    = zone_size[`SIZE_HI:`SIZE_LO]; // RULE18
    assign size_ok   = (size_n >= `SIZE_MIN)
                    && (size_n <= `SIZE_MAX); // RULE11
    assign user_mask = 16'hFFFF << size_n;
    assign user_base = {zone_base_high, zone_base_low}; // RULE17

    // Each zone selects from its own enable and the four zone registers.
    always_comb begin
        kbd_hit = zone_config[`CFG_KBD_ALT] ?
                  pair_hit(io_addr, `KBD_ALT_A, `KBD_ALT_B) :
                  pair_hit(io_addr, `KBD_ADDR_A, `KBD_ADDR_B); // RULE8
        pwr_hit = zone_config[`CFG_PWR_ALT] ?
                  pair_hit(io_addr, `PWR_ALT_A, `PWR_ALT_B) :
                  pair_hit(io_addr, `PWR_ADDR_A, `PWR_ADDR_B); // RULE9
        unique case (zone_config[`CFG_RTC_HI:`CFG_RTC_LO]) // RULE10
            `RTC_OFF:     rtc_hit = 1'b0;
            `RTC_LEGACY:  rtc_hit = pair_hit(io_addr, `RTC_ADDR_A,
                                             `RTC_ADDR_B);
            `RTC_ALT_ONE: rtc_hit = pair_hit(io_addr, `RTC_ALT1_A,
                                             `RTC_ALT1_B);
            `RTC_ALT_TWO: rtc_hit = pair_hit(io_addr, `RTC_ALT2_A,
                                             `RTC_ALT2_B);
        endcase
        sel_port.sel = '0; // RULE14
        if (active) begin // RULE20
            sel_port.sel[`ZONE_KBD]  = zone_config[`CFG_KBD_EN] && kbd_hit;
            sel_port.sel[`ZONE_PWR]  = zone_config[`CFG_PWR_EN] && pwr_hit;
            sel_port.sel[`ZONE_RTC]  = rtc_hit; // RULE6
            sel_port.sel[`ZONE_USER] = zone_config[`CFG_USER_EN] && size_ok
                && (((io_addr ^ user_base) & user_mask) == 16'h0000); // RULE19
            sel_port.sel[`ZONE_DBG]  = zone_config[`CFG_DBG_EN]
                && (io_addr == `DBG_ADDR); // RULE12
        end
    end

endmodule : io_zone_matcher

/* design/ext_cs_router.sv */
// Routes internal zone selects onto the two external chip selects.
`include "zone_decode_params.svh"
module ext_cs_router (
    zone_sel_if.sink                           sel_port,
    input  wire logic [`NUM_CS-1:0][`NUM_ZONES-1:0] cs_map,
    output logic      [`NUM_CS-1:0]            cs_hit,
    output logic                               has_cs
);

    // The external bus side owns the mapping; the decoder only selects.
    generate
        for (genvar i = 0; i < `NUM_CS; i++) begin : g_cs
            assign cs_hit[i] = |(sel_port.sel & cs_map[i]); // RULE7
        end
    endgenerate

    // A selected zone with no chip select is answered locally.
    assign has_cs = |cs_hit; // RULE13

endmodule : ext_cs_router

/* design/lpc_ext_bus_io_zone_decode.sv */
// Configuration registers and I/O zone forwarding to the external bus.
//
// Notes on behaviour
// RULE1 - Activate bit 0 clear hides function registers.
// RULE2 - Base low byte bits 3-0 read zero.
// RULE3 - Interrupt number and type read-only zero.
// RULE4 - Both DMA registers report no channel while active.
// RULE5 - Forward I/O cycles only inside zone map.
// RULE6 - Five zones, each enabled, each own select.
// RULE7 - External side maps zone selects to chip selects.
// RULE8 - Keyboard zone 60h/64h plus one alternate.
// RULE9 - Power zone 62h/66h plus one alternate.
// RULE10 - Clock zone 70h/71h plus two alternates.
// RULE11 - User zone two-to-n bytes, n 1..8, aligned.
// RULE12 - Separately enabled debug port zone.
// RULE13 - Zone without chip select reads zero, drops writes.
// RULE14 - Decode uses only zone config, base, size.
// RULE15 - Two writable interrupt mapping registers, reset zero.
// RULE16 - Four writable memory window registers, reset zero.
// RULE17 - Zone base high and low bytes, reset zero.
// RULE18 - Size register low nibble holds exponent n.
// RULE19 - User zone compares bits above low n.
// RULE20 - Inactive function selects and forwards nothing.
//
// The plain strobed port was decided locally.
`include "zone_decode_params.svh"
module lpc_ext_bus_io_zone_decode (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    output logic      [7:0]  cfg_rdata,
    input  wire logic        io_req,
    input  wire logic        io_write,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    output logic             io_claim,
    output logic             io_busy,
    output logic      [7:0]  io_rdata,
    output logic             io_done,
    output logic      [1:0]  ext_chip_selects,
    output logic      [15:0] ext_addr,
    output logic      [7:0]  ext_wdata,
    output logic             ext_wr,
    output logic             ext_rd,
    input  wire logic [7:0]  ext_rdata
);

    zone_decode_pkg::state_type state_reg;
    zone_decode_pkg::state_type state_next;

    zone_sel_if sel_bus ();

    logic                 active;
    logic [`NUM_CS-1:0]   cs_hit;
    logic                 has_cs;
    logic                 idle;

    // Register read decode; every hidden or unmapped location reads zero.
    function automatic logic [7:0] reg_read(
        input logic [7:0]                 addr,
        input zone_decode_pkg::state_type s
    );
        logic on;
        on = s.activate[`ACTIVATE_BIT];
        reg_read = `RESET_BYTE;
        if (addr == `OFS_ACTIVATE) begin
            reg_read = s.activate;
        end else if (on) begin // RULE1
            unique case (addr)
                `OFS_BASE_HIGH:    reg_read = s.base_high;
                `OFS_BASE_LOW:     reg_read = s.base_low & `BASE_LOW_RW_MASK;
                `OFS_IRQ_NUM_WAKE: reg_read = `RESET_BYTE; // RULE3
                `OFS_IRQ_TYPE:     reg_read = `RESET_BYTE; // RULE3
                `OFS_DMA_FIRST:    reg_read = `NO_DMA_CODE; // RULE4
                `OFS_DMA_SECOND:   reg_read = `NO_DMA_CODE; // RULE4
                `OFS_ZONE_CONFIG:  reg_read = s.zone_config;
                `OFS_ZONE_BASE_HI: reg_read = s.zone_base_high;
                `OFS_ZONE_BASE_LO: reg_read = s.zone_base_low;
                `OFS_ZONE_SIZE:    reg_read = s.zone_size;
                `OFS_MEM_CONFIG:   reg_read = s.mem_config;
                `OFS_MEM_BASE_HI:  reg_read = s.mem_base_high;
                `OFS_MEM_BASE_LO:  reg_read = s.mem_base_low;
                `OFS_MEM_SIZE:     reg_read = s.mem_size;
                `OFS_IRQ_MAP_AB:   reg_read = s.irq_map_ab;
                `OFS_IRQ_MAP_CD:   reg_read = s.irq_map_cd;
                `OFS_CS0_MAP:      reg_read = {3'h0, s.cs0_map};
                `OFS_CS1_MAP:      reg_read = {3'h0, s.cs1_map};
                default:           reg_read = `RESET_BYTE;
            endcase
        end
    endfunction : reg_read

    assign active = state_reg.activate[`ACTIVATE_BIT];

    // Address decode of the five zones.
    io_zone_matcher u_matcher (
        .active         (active),
        .io_addr        (io_addr),
        .zone_config    (state_reg.zone_config),
        .zone_base_high (state_reg.zone_base_high),
        .zone_base_low  (state_reg.zone_base_low),
        .zone_size      (state_reg.zone_size),
        .sel_port       (sel_bus.source)
    );

    // Chip-select assignment owned by the external bus side.
    ext_cs_router u_router (
        .sel_port (sel_bus.sink),
        .cs_map   ({state_reg.cs1_map, state_reg.cs0_map}),
        .cs_hit   (cs_hit),
        .has_cs   (has_cs)
    );

    // The host sees a claim only when idle, so cycles never overlap.
    assign idle     = (state_reg.phase == zone_decode_pkg::PH_IDLE);
    assign io_claim = idle && (|sel_bus.sel); // RULE5
    assign io_busy  = !idle;

    // Outputs come straight from the registered state.
    assign cfg_rdata        = state_reg.cfg_rdata;
    assign io_rdata         = state_reg.io_rdata;
    assign io_done          = state_reg.io_done;
    assign ext_chip_selects = state_reg.chip_selects;
    assign ext_addr         = state_reg.ext_addr;
    assign ext_wdata        = state_reg.ext_wdata;
    assign ext_wr           = state_reg.ext_wr;
    assign ext_rd           = state_reg.ext_rd;

    // Next-state logic: register writes, read data and the I/O sequence.
    always_comb begin
        state_next              = state_reg;
        state_next.cfg_rdata    = `RESET_BYTE;
        state_next.io_done      = 1'b0;
        state_next.ext_wr       = 1'b0;
        state_next.ext_rd       = 1'b0;
        state_next.chip_selects = 2'h0;

        // Read data stand for exactly one cycle after the strobe.
        if (cfg_rd) begin
            state_next.cfg_rdata = reg_read(cfg_addr, state_reg);
        end

        // Activate stays writable so software can wake the function.
        if (cfg_wr) begin
            if (cfg_addr == `OFS_ACTIVATE) begin
                state_next.activate = cfg_wdata;
            end else if (active) begin // RULE1
                unique case (cfg_addr)
                    `OFS_BASE_HIGH:    state_next.base_high = cfg_wdata;
                    `OFS_BASE_LOW:     state_next.base_low =
                        cfg_wdata & `BASE_LOW_RW_MASK; // RULE2
                    `OFS_ZONE_CONFIG:  state_next.zone_config = cfg_wdata;
                    `OFS_ZONE_BASE_HI: state_next.zone_base_high =
                        cfg_wdata; // RULE17
                    `OFS_ZONE_BASE_LO: state_next.zone_base_low =
                        cfg_wdata; // RULE17
                    `OFS_ZONE_SIZE:    state_next.zone_size = cfg_wdata;
                    `OFS_MEM_CONFIG:   state_next.mem_config = cfg_wdata;
                    `OFS_MEM_BASE_HI:  state_next.mem_base_high =
                        cfg_wdata; // RULE16
                    `OFS_MEM_BASE_LO:  state_next.mem_base_low =
                        cfg_wdata; // RULE16
                    `OFS_MEM_SIZE:     state_next.mem_size = cfg_wdata;
                    `OFS_IRQ_MAP_AB:   state_next.irq_map_ab =
                        cfg_wdata; // RULE15
                    `OFS_IRQ_MAP_CD:   state_next.irq_map_cd =
                        cfg_wdata; // RULE15
                    `OFS_CS0_MAP:      state_next.cs0_map =
                        cfg_wdata[`NUM_ZONES-1:0];
                    `OFS_CS1_MAP:      state_next.cs1_map =
                        cfg_wdata[`NUM_ZONES-1:0];
                    default:           state_next.base_high =
                        state_reg.base_high;
                endcase
            end
        end

        // A claimed cycle either goes out on the bus or is answered here.
        unique case (state_reg.phase)
            zone_decode_pkg::PH_IDLE: begin
                if (io_req && io_claim) begin
                    if (has_cs) begin // RULE5
                        state_next.chip_selects = cs_hit; // RULE7
                        state_next.ext_addr     = io_addr;
                        state_next.ext_wdata    = io_wdata;
                        state_next.ext_wr       = io_write;
                        state_next.ext_rd       = !io_write;
                        state_next.phase        = zone_decode_pkg::PH_ACCESS;
                    end else begin
                        state_next.io_rdata = `RESET_BYTE; // RULE13
                        state_next.io_done  = 1'b1;
                    end
                end
            end
            zone_decode_pkg::PH_ACCESS: begin
                // Writes return zero data; reads capture the bus byte.
                state_next.io_rdata = state_reg.ext_rd ? ext_rdata
                                                       : `RESET_BYTE;
                state_next.io_done  = 1'b1;
                state_next.phase    = zone_decode_pkg::PH_IDLE;
            end
        endcase
    end

    // All state resets together; memory and map registers start cleared.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg                <= '0;
            state_reg.activate       <= `RESET_BYTE; // RULE1
            state_reg.base_low       <= `RESET_BYTE; // RULE2
            state_reg.zone_size      <= `RESET_BYTE; // RULE18
            state_reg.phase          <= zone_decode_pkg::PH_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : lpc_ext_bus_io_zone_decode

/* verification/zone_decode_props.sv */
// Checker for the zone decoder's register and I/O forwarding ports.
module zone_decode_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  cfg_addr,
    input wire logic [7:0]  cfg_wdata,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [7:0]  cfg_rdata,
    input wire logic        io_req,
    input wire logic        io_write,
    input wire logic [15:0] io_addr,
    input wire logic [7:0]  io_wdata,
    input wire logic        io_claim,
    input wire logic        io_busy,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_done,
    input wire logic [1:0]  ext_chip_selects,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0]  ext_wdata,
    input wire logic        ext_wr,
    input wire logic        ext_rd,
    input wire logic [7:0]  ext_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic act_reg;

    // Mirror of the activate bit, because only the ports are visible here.
    always_ff @(posedge clk) begin
        if (rst) begin
            act_reg <= 1'b0;
        end else if (cfg_wr && cfg_addr == 8'h30) begin
            act_reg <= cfg_wdata[0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // The two ways a taken I/O cycle may finish.
    sequence s_fwd;
        (ext_rd || ext_wr) ##1 io_done;
    endsequence
    sequence s_nocs;
        io_done && !ext_rd && !ext_wr;
    endsequence

    a_rdata_idle: assert property (!$past(cfg_rd) |->
        cfg_rdata == 8'h00)
        else $error("cfg_rdata not zero outside a read answer");
    a_inactive_hide: assert property (!act_reg && cfg_rd &&
        cfg_addr != 8'h30 |=> cfg_rdata == 8'h00)
        else $error("register visible while inactive");
    a_low_nibble: assert property (cfg_rd && cfg_addr == 8'h61
        |=> cfg_rdata[3:0] == 4'h0)
        else $error("base low nibble not zero");
    a_irq_zero: assert property (cfg_rd && (cfg_addr == 8'h70 ||
        cfg_addr == 8'h71) |=> cfg_rdata == 8'h00)
        else $error("interrupt register not zero");
    a_dma_code: assert property (act_reg && cfg_rd &&
        (cfg_addr == 8'h74 || cfg_addr == 8'h75) |=> cfg_rdata == 8'h04)
        else $error("dma register not reporting no channel");
    a_no_claim: assert property (!act_reg |-> !io_claim)
        else $error("claim while inactive");
    a_done_latency: assert property (io_req && io_claim |=>
        s_nocs or s_fwd)
        else $error("io_done latency wrong");
    a_fwd_cause: assert property ((ext_rd || ext_wr) |->
        $past(io_req && io_claim))
        else $error("external strobe without a taken request");
    a_cs_strobe: assert property ((ext_rd || ext_wr) |->
        ext_chip_selects != 2'h0)
        else $error("forwarded access without chip select");
    a_cs_idle: assert property (!(ext_rd || ext_wr) |->
        ext_chip_selects == 2'h0)
        else $error("chip select outside an access");
    a_read_pass: assert property (ext_rd |=>
        io_done && io_rdata == $past(ext_rdata))
        else $error("read data not passed to host");
    a_write_data: assert property (ext_wr |->
        ext_addr == $past(io_addr) && ext_wdata == $past(io_wdata))
        else $error("write address or data not forwarded");
    a_busy_refuse: assert property (io_busy |->
        !io_claim && (ext_rd || ext_wr))
        else $error("busy without an access or with a claim");
endmodule : zone_decode_props

/* verification/ext_bus_model.sv */
// Model of the peripherals on the external bus answering reads.
module ext_bus_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [1:0]  ext_chip_selects,
    input  wire logic [15:0] ext_addr,
    input  wire logic        ext_rd,
    output logic      [7:0]  ext_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] noise_reg;

    // A changing pattern outside reads keeps stale data from passing.
    always_ff @(posedge clk) begin
        noise_reg <= rst ? 8'h3C : noise_reg + 8'h47;
    end

    // A selected peripheral answers in the strobe cycle, never stalling.
    assign ext_rdata = (ext_rd && ext_chip_selects != 2'h0) ?
                       ext_addr[7:0] ^ 8'hA5 : noise_reg;
endmodule : ext_bus_model

/* verification/tb.sv */
// Self-checking bench for the zone decoder: registers and I/O zones.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, cfg_wr, cfg_rd, io_req, io_write, io_claim;
    logic        io_busy, io_done, ext_wr, ext_rd;
    logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, io_wdata, io_rdata;
    logic [7:0]  ext_wdata, ext_rdata;
    logic [15:0] io_addr, ext_addr;
    logic [1:0]  ext_chip_selects;
    int          n_errors = 0;
    int          n_checks = 0;
    localparam logic [7:0] LOW [8] = '{8'h30, 8'h60, 8'h61, 8'h70,
        8'h71, 8'h74, 8'h75, 8'h50};
    localparam logic [7:0] MSK [8] = '{8'hFF, 8'hFF, 8'hF0, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};

    always #2 clk = ~clk;

    lpc_ext_bus_io_zone_decode dut (.clk(clk), .rst(rst),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .io_req(io_req),
        .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_claim(io_claim), .io_busy(io_busy), .io_rdata(io_rdata),
        .io_done(io_done), .ext_chip_selects(ext_chip_selects),
        .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_wr(ext_wr),
        .ext_rd(ext_rd), .ext_rdata(ext_rdata));
    ext_bus_model model (.clk(clk), .rst(rst), .ext_rd(ext_rd),
        .ext_chip_selects(ext_chip_selects), .ext_addr(ext_addr),
        .ext_rdata(ext_rdata));

    // Offsets F0h to F9h follow the eight low offsets in one index.
    function automatic logic [7:0] ofs(input int i);
        return i < 8 ? LOW[i] : 8'(8'hE8 + i);
    endfunction : ofs

    task automatic check(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Writes leave the strobe up so a following access can be back to back.
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        cfg_rd <= 1'b0;
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
    endtask : wr

    task automatic rd(input logic [7:0] a, e);
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        #1;
        check("cfg_rdata", cfg_rdata, e);
    endtask : rd

    // One host cycle; a miss must give no answer within four cycles.
    task automatic io(input logic [15:0] a, input logic w, hit,
                      input logic [1:0] cs);
        logic [1:0] seen;
        int         n;
        seen = 2'h0;
        @(posedge clk);
        cfg_wr <= 1'b0;
        io_req <= 1'b1;
        io_write <= w;
        io_addr <= a;
        io_wdata <= ~a[7:0];
        #1;
        check("io_claim", io_claim, hit);
        @(posedge clk);
        io_req <= 1'b0;
        for (n = 1; n < 5; n++) begin
            #1;
            if (ext_rd || ext_wr) seen = ext_chip_selects;
            if (io_done) break;
            @(posedge clk);
        end
        check("io_cycles", 16'(n),
              16'(hit ? (cs != 2'h0 ? 2 : 1) : 5));
        check("chip_sel", seen, cs);
        if (hit) check("io_rdata", io_rdata,
                       (w || cs == 2'h0) ? 8'h00 : a[7:0] ^ 8'hA5);
    endtask : io

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // The whole sequence takes under two thousand cycles.
    initial begin
        #40000;
        n_errors++;
        end_sim;
    end

    initial begin
        {clk, cfg_wr, cfg_rd, io_req, io_write} = 5'h00;
        rst = 1'b1;
        {cfg_addr, cfg_wdata, io_wdata, io_addr} = 40'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(8'h30, 8'h00);
        wr(8'hF1, 8'h55);
        rd(8'h74, 8'h00);
        wr(8'h30, 8'h01);
        rd(8'hF1, 8'h00);
        for (int i = 1; i < 18; i++)
            rd(ofs(i),
               (i == 5 || i == 6) ? 8'h04 : 8'h00);
        $display("test reset_values done");
        foreach (LOW[p]) if (p < 2) for (int i = 0; i < 18; i++) begin
            wr(ofs(i), p == 0 ? 8'hFF : 8'hA5);
            rd(ofs(i),
               ((p == 0 ? 8'hFF : 8'hA5) & (i < 8 ? MSK[i] : 8'hFF))
               | ((i == 5 || i == 6) ? 8'h04 : 8'h00));
        end
        $display("test register_access done");
        wr(8'hFA, 8'h0B);
        wr(8'hFB, 8'h1C);
        wr(8'hFA, 8'hEB);
        rd(8'hFA, 8'h0B);
        wr(8'hF1, 8'h01);
        wr(8'hF2, 8'h00);
        wr(8'hF3, 8'h04);
        wr(8'hF0, 8'hD5);
        io(16'h0060, 0, 1, 2'h1);
        io(16'h0064, 1, 1, 2'h1);
        io(16'h0068, 0, 0, 2'h0);
        io(16'h0062, 0, 1, 2'h1);
        io(16'h0066, 1, 1, 2'h1);
        io(16'h006A, 0, 0, 2'h0);
        io(16'h0070, 0, 1, 2'h2);
        io(16'h0071, 1, 1, 2'h2);
        io(16'h0072, 0, 0, 2'h0);
        io(16'h0080, 0, 1, 2'h2);
        io(16'h0100, 0, 1, 2'h3);
        io(16'h010F, 1, 1, 2'h3);
        io(16'h0110, 0, 0, 2'h0);
        wr(8'hF0, 8'hEF);
        io(16'h006C, 0, 1, 2'h1);
        io(16'h0060, 0, 0, 2'h0);
        io(16'h006E, 0, 1, 2'h1);
        io(16'h0073, 0, 1, 2'h2);
        wr(8'hF0, 8'h7F);
        io(16'h0075, 0, 1, 2'h2);
        io(16'h0080, 0, 0, 2'h0);
        wr(8'hF3, 8'h08);
        io(16'h01FF, 0, 1, 2'h3);
        io(16'h0200, 0, 0, 2'h0);
        wr(8'hF3, 8'h09);
        io(16'h0100, 0, 0, 2'h0);
        wr(8'hF3, 8'hF1);
        io(16'h0101, 0, 1, 2'h3);
        io(16'h0102, 0, 0, 2'h0);
        $display("test zone_decode done");
        wr(8'hFA, 8'h0A);
        io(16'h006C, 0, 1, 2'h0);
        io(16'h0068, 1, 1, 2'h0);
        wr(8'h30, 8'h00);
        io(16'h0074, 0, 0, 2'h0);
        $display("test no_select_and_inactive done");
        end_sim;
    end
endmodule : tb

bind lpc_ext_bus_io_zone_decode zone_decode_props props (.clk(clk),
    .rst(rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .io_req(io_req), .io_write(io_write), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_claim(io_claim), .io_busy(io_busy),
    .io_rdata(io_rdata), .io_done(io_done), .ext_addr(ext_addr),
    .ext_chip_selects(ext_chip_selects), .ext_wdata(ext_wdata),
    .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_rdata(ext_rdata));
